//--- rtl/sir_cfg.svh
`ifndef SIR_CFG_SVH
`define SIR_CFG_SVH

// register byte offsets on the sensor register port
`define SIR_ADDR_PIN_CFG    8'h03
`define SIR_ADDR_ENABLE     8'h04
`define SIR_ADDR_MODE_ONE   8'h05
`define SIR_ADDR_MODE_TWO   8'h06
`define SIR_ADDR_STATUS     8'h21

// event_pin_config fields
`define SIR_PIN_OE_BIT      0
`define SIR_PIN_MODE_BIT    1
`define SIR_PIN_CFG_MASK    8'h03

// event_enable / event_status bit positions
`define SIR_AMB_LO          0
`define SIR_AMB_HI          1
`define SIR_PROX_BASE       2
`define SIR_CMD_BIT         5
`define SIR_FLAG_MASK       8'h3f

// mode field positions
`define SIR_AMB_MODE_LO     0
`define SIR_PROX1_MODE_LO   4
`define SIR_PROX2_MODE_LO   6
`define SIR_PROX3_MODE_LO   0
`define SIR_CMD_MODE_LO     2

// reset values
`define SIR_RST_BYTE        8'h00
`define SIR_RST_WORD        16'h0000

// response codes with this bit set are error codes
`define SIR_RESP_ERR_BIT    7

`endif

//--- rtl/sir_irq_top.sv
`timescale 1ns/1ns
`include "sir_cfg.svh"
// Contract
// - request pin asserts while any bit of enable AND status is set; in deassert mode 1 a status read drops it until a fresh event
// - pin driven only while pin output enable bit 0 is set
// - with deassert mode 0 request stays until host clears status
// - writing one clears that status bit; zeros leave bits unchanged
// - prox one enabled, mode 00: flag after every sample
// - prox one mode 01: flag when threshold crossed either way
// - prox one mode 11: flag when sample above threshold; off if disabled
// - prox two same, enable bit 3, mode one bits 7:6
// - prox three same, enable bit 4, mode two bits 1:0
// - prox thresholds use hysteresis, history, compressed 8-bit codes
// - ambient enable 01, mode 000: flag bit 0 every visible sample
// - enable bit 0, mode x01: visible leaves window sets flag bit 0
// - enable bit 1, mode 10x: visible enters window sets flag bit 1
// - enable bit 0, mode x11: infrared leaves window sets bit 0
// - enable bit 1, mode 11x: infrared enters window sets bit 1
// - command enable bit 5: mode 00 every response, 01 new errors
module sir_irq_top
    import sir_pkg::*;
(
    // clock and reset
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESET,
    // register port
    input  wire logic        I_WR_EN,
    input  wire logic        I_RD_EN,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [7:0]  I_WR_DATA,
    output logic      [7:0]  O_RD_DATA,
    // proximity samples
    input  wire logic        I_PROX_ONE_VALID,
    input  wire logic [15:0] I_PROX_ONE_DATA,
    input  wire logic        I_PROX_TWO_VALID,
    input  wire logic [15:0] I_PROX_TWO_DATA,
    input  wire logic        I_PROX_THREE_VALID,
    input  wire logic [15:0] I_PROX_THREE_DATA,
    // proximity threshold settings, compressed codes; history check is a plain sample count
    input  wire logic [7:0]  I_PROX_ONE_THRESHOLD,
    input  wire logic [7:0]  I_PROX_TWO_THRESHOLD,
    input  wire logic [7:0]  I_PROX_THREE_THRESHOLD,
    input  wire logic [7:0]  I_PROX_HYSTERESIS,
    input  wire logic [7:0]  I_PROX_HISTORY_CHECK,
    // ambient samples and window, compressed codes
    input  wire logic        I_VISIBLE_VALID,
    input  wire logic [15:0] I_VISIBLE_LIGHT_CHANNEL,
    input  wire logic        I_INFRARED_VALID,
    input  wire logic [15:0] I_INFRARED_LIGHT_CHANNEL,
    input  wire logic [7:0]  I_AMBIENT_LOW_THRESHOLD,
    input  wire logic [7:0]  I_AMBIENT_HIGH_THRESHOLD,
    // command responses
    input  wire logic        I_RESPONSE_VALID,
    input  wire logic [7:0]  I_RESPONSE,
    // open-drain event request pin, active low
    output logic             O_EVENT_REQ_N,
    output logic             O_EVENT_REQ_OE
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]  event_pin_config_ff;
    logic [7:0]  event_enable_ff;
    logic [7:0]  event_mode_one_ff;
    logic [7:0]  event_mode_two_ff;
    logic [7:0]  event_status_ff;
    logic [7:0]  nxt_event_status;
    logic [7:0]  set_flags;
    logic [7:0]  clr_flags;
    logic [7:0]  rd_data_ff;
    logic [7:0]  nxt_rd_data;
    logic        wr_status;
    logic        rd_status;

    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] target);
        return addr == target;
    endfunction : hit

    assign wr_status = I_WR_EN && hit(I_ADDR, `SIR_ADDR_STATUS);
    assign rd_status = I_RD_EN && hit(I_ADDR, `SIR_ADDR_STATUS);

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            event_pin_config_ff <= `SIR_RST_BYTE;
        end else if (I_WR_EN && hit(I_ADDR, `SIR_ADDR_PIN_CFG)) begin
            event_pin_config_ff <= I_WR_DATA & `SIR_PIN_CFG_MASK;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            event_enable_ff <= `SIR_RST_BYTE;
        end else if (I_WR_EN && hit(I_ADDR, `SIR_ADDR_ENABLE)) begin
            event_enable_ff <= I_WR_DATA & `SIR_FLAG_MASK;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            event_mode_one_ff <= `SIR_RST_BYTE;
        end else if (I_WR_EN && hit(I_ADDR, `SIR_ADDR_MODE_ONE)) begin
            event_mode_one_ff <= I_WR_DATA;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            event_mode_two_ff <= `SIR_RST_BYTE;
        end else if (I_WR_EN && hit(I_ADDR, `SIR_ADDR_MODE_TWO)) begin
            event_mode_two_ff <= I_WR_DATA & 8'h0f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // proximity channels

    logic [2:0]  prox_valid;
    logic [15:0] prox_data [3];
    logic [7:0]  prox_thr  [3];
    logic [1:0]  prox_mode [3];
    logic [2:0]  prox_event;

    assign prox_valid = {I_PROX_THREE_VALID, I_PROX_TWO_VALID,
                         I_PROX_ONE_VALID};
    assign prox_data[0] = I_PROX_ONE_DATA;
    assign prox_data[1] = I_PROX_TWO_DATA;
    assign prox_data[2] = I_PROX_THREE_DATA;
    assign prox_thr[0]  = I_PROX_ONE_THRESHOLD;
    assign prox_thr[1]  = I_PROX_TWO_THRESHOLD;
    assign prox_thr[2]  = I_PROX_THREE_THRESHOLD;
    assign prox_mode[0] =
        event_mode_one_ff[`SIR_PROX1_MODE_LO +: 2];
    assign prox_mode[1] =
        event_mode_one_ff[`SIR_PROX2_MODE_LO +: 2];
    assign prox_mode[2] =
        event_mode_two_ff[`SIR_PROX3_MODE_LO +: 2];

    // one checker per channel; each owns its hysteresis and history state
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_prox
            sir_prox_check u_check (
                .i_clk       (I_REF_CLK),
                .i_reset     (I_RESET),
                .i_valid     (prox_valid[g]),
                .i_sample    (prox_data[g]),
                .i_enable    (event_enable_ff[`SIR_PROX_BASE + g]),
                .i_mode      (prox_mode[g]),
                .i_thr_code  (prox_thr[g]),
                .i_hyst_code (I_PROX_HYSTERESIS),
                .i_history   (I_PROX_HISTORY_CHECK),
                .o_event     (prox_event[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // ambient window

    sir_level_type amb_lo;
    sir_level_type amb_hi;
    logic [2:0]    amb_mode;
    logic [1:0]    amb_en;
    logic [1:0]    amb_valid;
    logic [1:0]    now_inside;
    logic [1:0]    inside_ff;
    logic [1:0]    exit_evt;
    logic [1:0]    enter_evt;
    logic [1:0]    amb_set;

    assign amb_mode  = event_mode_one_ff[`SIR_AMB_MODE_LO +: 3];
    assign amb_en    = event_enable_ff[`SIR_AMB_HI:`SIR_AMB_LO];
    assign amb_valid = {I_INFRARED_VALID, I_VISIBLE_VALID};
    assign amb_lo    = sir_expand(I_AMBIENT_LOW_THRESHOLD);
    assign amb_hi    = sir_expand(I_AMBIENT_HIGH_THRESHOLD);

    function automatic logic in_window(input sir_level_type v,
                                       input sir_level_type lo,
                                       input sir_level_type hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_window

    assign now_inside[0] = in_window(I_VISIBLE_LIGHT_CHANNEL, amb_lo, amb_hi);
    assign now_inside[1] = in_window(I_INFRARED_LIGHT_CHANNEL, amb_lo,
                                     amb_hi);

    // both channels tracked always, so a mode change sees a current state
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            inside_ff <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (amb_valid[i]) begin
                    inside_ff[i] <= now_inside[i];
                end
            end
        end
    end

    assign exit_evt  = amb_valid & inside_ff & ~now_inside;
    assign enter_evt = amb_valid & ~inside_ff & now_inside;

    // combinations outside the listed ones are undefined; host avoids them
    always_comb begin
        amb_set = 2'b00;
        if (amb_en == 2'b01 && amb_mode == 3'b000 && I_VISIBLE_VALID) begin
            amb_set[0] = 1'b1;
        end
        if (amb_en[0] && amb_mode[0]) begin
            // mode bit 1 picks infrared over visible
            amb_set[0] = exit_evt[amb_mode[1]];
        end
        if (amb_en[1] && amb_mode[2]) begin
            // mode bit 1 picks infrared over visible here as well
            amb_set[1] = enter_evt[amb_mode[1]];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command responses

    logic [7:0] last_resp_ff;
    logic       cmd_set;
    logic       cmd_err_only;

    assign cmd_err_only = event_mode_two_ff[`SIR_CMD_MODE_LO];

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            last_resp_ff <= `SIR_RST_BYTE;
        end else if (I_RESPONSE_VALID) begin
            last_resp_ff <= I_RESPONSE;
        end
    end

    assign cmd_set = event_enable_ff[`SIR_CMD_BIT] && I_RESPONSE_VALID
                     && (!cmd_err_only
                         || (I_RESPONSE[`SIR_RESP_ERR_BIT]
                             && I_RESPONSE != last_resp_ff));

    ////////////////////////////////////////////////////////////////////////
    // sticky status

    always_comb begin
        set_flags = 8'h00;
        set_flags[`SIR_AMB_HI:`SIR_AMB_LO] = amb_set;
        set_flags[`SIR_PROX_BASE +: 3]     = prox_event;
        set_flags[`SIR_CMD_BIT]            = cmd_set;
        clr_flags = wr_status ? I_WR_DATA : 8'h00;
        // a set in the same cycle as its clear wins, so no event is lost
        nxt_event_status = ((event_status_ff & ~clr_flags) | set_flags)
                           & `SIR_FLAG_MASK;
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            event_status_ff <= `SIR_RST_BYTE;
        end else begin
            event_status_ff <= nxt_event_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read

    always_comb begin
        nxt_rd_data = rd_data_ff;
        if (I_RD_EN) begin
            unique case (I_ADDR)
                `SIR_ADDR_PIN_CFG:  nxt_rd_data = event_pin_config_ff;
                `SIR_ADDR_ENABLE:   nxt_rd_data = event_enable_ff;
                `SIR_ADDR_MODE_ONE: nxt_rd_data = event_mode_one_ff;
                `SIR_ADDR_MODE_TWO: nxt_rd_data = event_mode_two_ff;
                `SIR_ADDR_STATUS:   nxt_rd_data = event_status_ff;
                default:            nxt_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            rd_data_ff <= `SIR_RST_BYTE;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign O_RD_DATA = rd_data_ff;

    ////////////////////////////////////////////////////////////////////////
    // request pin

    logic [7:0] active;
    logic       new_active;
    logic       auto_armed_ff;
    logic       req_ff;
    logic       nxt_req;
    logic       req_n_ff;

    assign active     = event_enable_ff & event_status_ff;
    assign new_active = |(event_enable_ff & set_flags);

    // deassert mode 1: a status read drops the pin until a fresh event
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            auto_armed_ff <= 1'b1;
        end else if (new_active) begin
            auto_armed_ff <= 1'b1;
        end else if (rd_status) begin
            auto_armed_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_req = |active;
        if (event_pin_config_ff[`SIR_PIN_MODE_BIT]) begin
            nxt_req = |active && auto_armed_ff;
        end
        nxt_req = nxt_req && event_pin_config_ff[`SIR_PIN_OE_BIT];
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // pin value mirrors the request; only its low level is ever driven
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            req_n_ff <= 1'b1;
        end else begin
            req_n_ff <= !nxt_req;
        end
    end

    // open drain: only ever pulls low, released otherwise
    assign O_EVENT_REQ_N  = req_n_ff;
    assign O_EVENT_REQ_OE = req_ff;

endmodule : sir_irq_top

//--- rtl/sir_pkg.sv
package sir_pkg;

    typedef enum logic [1:0] {
        SIR_PM_EVERY = 2'b00,
        SIR_PM_CROSS = 2'b01,
        SIR_PM_RSVD  = 2'b10,
        SIR_PM_ABOVE = 2'b11
    } sir_prox_mode_type;

    typedef logic [15:0] sir_level_type;

    // 8-bit compressed code: [7:4] exponent, [3:0] mantissa with hidden one
    function automatic sir_level_type sir_expand(input logic [7:0] code);
        logic [31:0] wide;
        wide = 32'h0;
        if (code != 8'h00) begin
            wide = ({27'h0, 1'b1, code[3:0]} << code[7:4]) >> 4;
        end
        return wide[15:0];
    endfunction : sir_expand

endpackage : sir_pkg

//--- rtl/sir_prox_check.sv
`timescale 1ns/1ns
module sir_prox_check
    import sir_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // sample
    input  wire logic        i_valid,
    input  wire logic [15:0] i_sample,
    // settings
    input  wire logic        i_enable,
    input  wire logic [1:0]  i_mode,
    input  wire logic [7:0]  i_thr_code,
    input  wire logic [7:0]  i_hyst_code,
    input  wire logic [7:0]  i_history,
    // result
    output logic             o_event
);

    sir_level_type     thr;
    sir_level_type     hyst;
    logic [16:0]       hi_lim;
    logic [15:0]       lo_lim;
    logic              cand_above;
    logic              flip;
    logic [7:0]        need;
    logic              above_ff;
    logic              nxt_above;
    logic [7:0]        agree_ff;
    logic              event_ff;
    logic              nxt_event;
    sir_prox_mode_type mode;

    assign mode = sir_prox_mode_type'(i_mode);

    always_comb begin
        thr    = sir_expand(i_thr_code);
        hyst   = sir_expand(i_hyst_code);
        hi_lim = {1'b0, thr} + {1'b0, hyst};
        lo_lim = (thr > hyst) ? (thr - hyst) : 16'h0000;
        need   = (i_history == 8'h00) ? 8'h01 : i_history;
        // the band between the limits keeps the present state
        cand_above = above_ff ? (i_sample >= lo_lim)
                              : ({1'b0, i_sample} > hi_lim);
        // history: the new side must hold for need samples in a row
        flip      = i_valid && (cand_above != above_ff)
                    && ((agree_ff + 8'h01) >= need);
        nxt_above = flip ? cand_above : above_ff;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            above_ff <= 1'b0;
        end else begin
            above_ff <= nxt_above;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            agree_ff <= 8'h00;
        end else if (i_valid) begin
            if (flip || (cand_above == above_ff)) begin
                agree_ff <= 8'h00;
            end else if (agree_ff != 8'hff) begin
                agree_ff <= agree_ff + 8'h01;
            end
        end
    end

    always_comb begin
        nxt_event = 1'b0;
        if (i_enable && i_valid) begin
            unique case (mode)
                SIR_PM_EVERY: nxt_event = 1'b1;
                SIR_PM_CROSS: nxt_event = flip;
                SIR_PM_ABOVE: nxt_event = nxt_above;
                SIR_PM_RSVD:  nxt_event = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            event_ff <= 1'b0;
        end else begin
            event_ff <= nxt_event;
        end
    end

    assign o_event = event_ff;

endmodule : sir_prox_check

//--- sim/sensor_irq_logic_bench.sv
`timescale 1ns/1ns
module sensor_irq_logic_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wd = 8'h00;
    logic [5:0]  vld = 6'h00;
    logic [15:0] smp = 16'h0000;
    logic [7:0]  thr = 8'h00;
    logic [7:0]  hyst = 8'h00;
    logic [7:0]  hist = 8'h00;
    logic [7:0]  rdat;
    logic        req_n;
    logic        req_oe;
    logic        line_n;
    logic        pend;
    int          n_fail = 0;
    int          total_checks = 0;

    always #2 clk = ~clk;

    sir_irq_top dut_u (
        .I_REF_CLK(clk), .I_RESET(rst), .I_WR_EN(we), .I_RD_EN(re),
        .I_ADDR(addr), .I_WR_DATA(wd), .O_RD_DATA(rdat),
        .I_PROX_ONE_VALID(vld[0]), .I_PROX_ONE_DATA(smp),
        .I_PROX_TWO_VALID(vld[1]), .I_PROX_TWO_DATA(smp),
        .I_PROX_THREE_VALID(vld[2]), .I_PROX_THREE_DATA(smp),
        .I_PROX_ONE_THRESHOLD(thr), .I_PROX_TWO_THRESHOLD(thr),
        .I_PROX_THREE_THRESHOLD(thr), .I_PROX_HYSTERESIS(hyst),
        .I_PROX_HISTORY_CHECK(hist), .I_VISIBLE_VALID(vld[3]),
        .I_VISIBLE_LIGHT_CHANNEL(smp), .I_INFRARED_VALID(vld[4]),
        .I_INFRARED_LIGHT_CHANNEL(smp), .I_AMBIENT_LOW_THRESHOLD(8'h40),
        .I_AMBIENT_HIGH_THRESHOLD(8'h50), .I_RESPONSE_VALID(vld[5]),
        .I_RESPONSE(smp[7:0]), .O_EVENT_REQ_N(req_n),
        .O_EVENT_REQ_OE(req_oe)
    );

    sir_host_model host_u (
        .i_req_n(req_n), .i_req_oe(req_oe), .o_line_n(line_n),
        .o_pending(pend)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // pin settles two cycles after the register write that moves it
    task automatic chk_pin(input logic exp);
        repeat (2) @(negedge clk);
        chk({7'h00, pend}, {7'h00, exp});
    endtask : chk_pin

    // bus tasks are entered at a falling edge and return at one;
    // a trailing idle cycle keeps back-to-back strobes apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        we = 1'b1;
        addr = a;
        wd = d;
        @(negedge clk);
        we = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        re = 1'b1;
        addr = a;
        @(negedge clk);
        re = 1'b0;
        chk(rdat, exp);
        @(negedge clk);
    endtask : rd

    // prox flags land two cycles after the strobe, others after one
    task automatic fire(input int ch, input logic [15:0] d);
        vld[ch] = 1'b1;
        smp = d;
        @(negedge clk);
        vld = 6'h00;
        repeat (3) @(negedge clk);
    endtask : fire

    ////////////////////////////////////////////////////////////////////////
    task automatic s_regs;
        rd(8'h03, 8'h00);
        rd(8'h21, 8'h00);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h03);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h3f);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h0f);
        wr(8'h05, 8'hc5);
        rd(8'h05, 8'hc5);
        rd(8'h07, 8'h00);
        wr(8'h05, 8'h00);
        wr(8'h06, 8'h00);
        wr(8'h03, 8'h01);
        chk_pin(1'b0);
    endtask : s_regs

    task automatic s_every;
        logic [7:0] m;
        for (int c = 0; c < 3; c++) begin
            m = 8'h04 << c;
            wr(8'h04, m);
            fire(c, 16'd0);
            chk_pin(1'b1);
            rd(8'h21, m);
            wr(8'h21, m);
            chk_pin(1'b0);
        end
    endtask : s_every

    // threshold 16, hysteresis 8: above past 24, below under 8
    task automatic s_thr;
        thr = 8'h40;
        hyst = 8'h30;
        wr(8'h04, 8'h04);
        wr(8'h05, 8'h30);
        fire(0, 16'd20);
        rd(8'h21, 8'h00);
        fire(0, 16'd30);
        rd(8'h21, 8'h04);
        wr(8'h21, 8'h04);
        fire(0, 16'd30);
        rd(8'h21, 8'h04);
        wr(8'h05, 8'h10);
        wr(8'h21, 8'h04);
        fire(0, 16'd40);
        rd(8'h21, 8'h00);
        fire(0, 16'd10);
        rd(8'h21, 8'h00);
        fire(0, 16'd2);
        rd(8'h21, 8'h04);
        wr(8'h21, 8'h04);
        wr(8'h04, 8'h00);
        fire(0, 16'd40);
        rd(8'h21, 8'h00);
        hist = 8'h02;
        wr(8'h04, 8'h04);
        fire(0, 16'd2);
        rd(8'h21, 8'h00);
        fire(0, 16'd2);
        rd(8'h21, 8'h04);
        wr(8'h21, 8'h04);
        hist = 8'h00;
    endtask : s_thr

    // window is 16 to 32
    task automatic s_amb;
        wr(8'h04, 8'h01);
        wr(8'h05, 8'h00);
        fire(3, 16'd5);
        rd(8'h21, 8'h01);
        wr(8'h05, 8'h01);
        wr(8'h21, 8'h01);
        fire(3, 16'd20);
        fire(3, 16'd50);
        rd(8'h21, 8'h01);
        wr(8'h04, 8'h02);
        wr(8'h05, 8'h04);
        wr(8'h21, 8'h01);
        fire(3, 16'd20);
        rd(8'h21, 8'h02);
        wr(8'h04, 8'h01);
        wr(8'h05, 8'h03);
        wr(8'h21, 8'h02);
        fire(4, 16'd20);
        fire(4, 16'd50);
        rd(8'h21, 8'h01);
        wr(8'h04, 8'h02);
        wr(8'h05, 8'h06);
        wr(8'h21, 8'h01);
        fire(4, 16'd20);
        rd(8'h21, 8'h02);
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h00);
        wr(8'h21, 8'h02);
        fire(3, 16'd20);
        rd(8'h21, 8'h00);
    endtask : s_amb

    task automatic s_cmd;
        wr(8'h04, 8'h20);
        fire(5, 16'h0001);
        rd(8'h21, 8'h20);
        wr(8'h06, 8'h04);
        wr(8'h21, 8'h20);
        fire(5, 16'h0002);
        rd(8'h21, 8'h00);
        fire(5, 16'h0088);
        rd(8'h21, 8'h20);
        wr(8'h21, 8'h20);
        fire(5, 16'h0088);
        rd(8'h21, 8'h00);
    endtask : s_cmd

    task automatic s_mask;
        wr(8'h06, 8'h00);
        wr(8'h04, 8'h24);
        fire(0, 16'd0);
        fire(5, 16'h0001);
        rd(8'h21, 8'h24);
        wr(8'h21, 8'h04);
        rd(8'h21, 8'h20);
        chk_pin(1'b1);
        wr(8'h04, 8'h04);
        chk_pin(1'b0);
        rd(8'h21, 8'h20);
        wr(8'h04, 8'h20);
        chk_pin(1'b1);
        wr(8'h03, 8'h00);
        chk_pin(1'b0);
        wr(8'h03, 8'h01);
        chk_pin(1'b1);
        wr(8'h03, 8'h03);
        rd(8'h21, 8'h20);
        chk_pin(1'b0);
        wr(8'h03, 8'h01);
        chk_pin(1'b1);
        wr(8'h21, 8'h3f);
        chk_pin(1'b0);
    endtask : s_mask

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        s_regs();
        s_every();
        s_thr();
        s_amb();
        s_cmd();
        s_mask();
        wrap_up();
    end

    // whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule : sensor_irq_logic_bench

//--- sim/sir_host_model.sv
`timescale 1ns/1ns
module sir_host_model (
    // pin from the device
    input  wire logic i_req_n,
    input  wire logic i_req_oe,
    // line as the host sees it
    output logic      o_line_n,
    output logic      o_pending
);
    // board pull-up holds the shared line high whenever nobody drives it
    assign o_line_n  = i_req_oe ? i_req_n : 1'b1;
    assign o_pending = ~o_line_n;
endmodule : sir_host_model

//--- sim/sir_irq_top_sva.sv
`timescale 1ns/1ns
module sir_irq_chk (
    // clock and reset
    input wire logic       I_REF_CLK,
    input wire logic       I_RESET,
    // register port
    input wire logic       I_WR_EN,
    input wire logic       I_RD_EN,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WR_DATA,
    input wire logic [7:0] O_RD_DATA,
    // event strobes
    input wire logic       I_PROX_ONE_VALID,
    input wire logic       I_PROX_TWO_VALID,
    input wire logic       I_PROX_THREE_VALID,
    input wire logic       I_VISIBLE_VALID,
    input wire logic       I_INFRARED_VALID,
    input wire logic       I_RESPONSE_VALID,
    // pin
    input wire logic       O_EVENT_REQ_OE
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RESET);

    logic strb;
    logic wr_st;
    assign strb = I_PROX_ONE_VALID | I_PROX_TWO_VALID | I_PROX_THREE_VALID
                | I_VISIBLE_VALID | I_INFRARED_VALID | I_RESPONSE_VALID;
    assign wr_st = I_WR_EN && I_ADDR == 8'h21;

    ////////////////////////////////////////////////////////////////////////
    mask_off_a: assert property (
        I_WR_EN && I_ADDR == 8'h04 && I_WR_DATA == 8'h00
        |=> ##1 !O_EVENT_REQ_OE)
        else $error("pin asserted with every enable off");
    pin_off_a: assert property (
        I_WR_EN && I_ADDR == 8'h03 && !I_WR_DATA[0] |=> ##1 !O_EVENT_REQ_OE)
        else $error("pin driven with output enable off");
    clear_all_a: assert property (
        wr_st && I_WR_DATA == 8'h3f && !strb && !$past(strb)
        |=> ##1 !O_EVENT_REQ_OE)
        else $error("pin stays after all flags cleared");
    sticky_pin_a: assert property (
        O_EVENT_REQ_OE && !$past(I_WR_EN) && !I_RD_EN && !$past(I_RD_EN)
        && !$past(I_RD_EN, 2) |=> O_EVENT_REQ_OE)
        else $error("pin dropped without a host write");
    cfg_rsvd_a: assert property (
        I_RD_EN && I_ADDR == 8'h03 |=> O_RD_DATA[7:2] == 6'h00)
        else $error("reserved pin config bits read nonzero");
    flag_rsvd_a: assert property (
        I_RD_EN && (I_ADDR == 8'h04 || I_ADDR == 8'h21)
        |=> O_RD_DATA[7:6] == 2'h0)
        else $error("unused flag bits read nonzero");
    rd_hold_a: assert property (
        !I_RD_EN |=> $stable(O_RD_DATA))
        else $error("read data changed without a read");
    enable_rb_a: assert property (
        I_WR_EN && I_ADDR == 8'h04 ##1 !I_WR_EN
        ##1 I_RD_EN && I_ADDR == 8'h04
        |=> O_RD_DATA == ($past(I_WR_DATA, 3) & 8'h3f))
        else $error("enable readback mismatch");

    pin_up_c: cover property ($rose(O_EVENT_REQ_OE));
    pin_dn_c: cover property ($fell(O_EVENT_REQ_OE));
    st_clr_c: cover property (wr_st && O_EVENT_REQ_OE);
endmodule : sir_irq_chk

bind sir_irq_top sir_irq_chk chk_u (
    .I_REF_CLK, .I_RESET, .I_WR_EN, .I_RD_EN, .I_ADDR, .I_WR_DATA,
    .O_RD_DATA, .I_PROX_ONE_VALID, .I_PROX_TWO_VALID,
    .I_PROX_THREE_VALID, .I_VISIBLE_VALID, .I_INFRARED_VALID,
    .I_RESPONSE_VALID, .O_EVENT_REQ_OE
);
